// [sample_path_pkg.sv]
// package: register map, field layout, reset values and types of the sample path control
package sample_path_pkg;

    // ======================================
    // register indices and byte addresses
    localparam logic [11:0] SWAP_DLY_IDX = 12'h09b;
    localparam logic [11:0] DITHER_IDX = 12'h09d;
    localparam logic [11:0] MARKER_IDX = 12'h160;
    localparam int ADDR_W = 14;
    localparam logic [13:0] SWAP_DLY_ADDR = {SWAP_DLY_IDX, 2'b00};
    localparam logic [13:0] DITHER_ADDR = {DITHER_IDX, 2'b00};
    localparam logic [13:0] MARKER_ADDR = {MARKER_IDX, 2'b00};

    // ======================================
    // reset values
    localparam logic [7:0] SWAP_DLY_RESET = 8'h07;
    localparam logic [7:0] DITHER_RESET = 8'h00;
    localparam logic [7:0] MARKER_RESET = 8'h00;

    // ======================================
    // field positions
    localparam int SWAP_DLY_MSB = 4;
    localparam int SWAP_DLY_W = 5;
    localparam int DITH_ERR_BIT = 2;
    localparam int DITH_AMP_BIT = 1;
    localparam int DITH_EN_BIT = 0;
    localparam int MARKER_EN_BIT = 0;

    // ======================================
    // link advertisement and dither source
    localparam logic [1:0] ILA_CTRL_BITS = 2'h0;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;

    // ======================================
    // types
    typedef struct packed {
        logic [SWAP_DLY_W-1:0] swap_dly;
        logic dith_err;
        logic dith_amp;
        logic dith_en;
        logic marker_en;
    } ctrl_t;

endpackage : sample_path_pkg

// [sample_path_control.sv]
// module: sample path control registers, swap select delay, dither, lsb marker and fifo
//
// Functional notes
// - swap select delayed by five-bit field, reset seven
// - delay field accepts zero through thirty-one
// - delay applies only during background swap
// - bit two picks dither rounding error handling
// - bit one picks small or large dither
// - bit zero enables dither in path
// - marker enable puts timestamp on link word lsb
// - lane alignment reports zero control bits

// ======================================
// fifo
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PTR_W:0] count_reg, count_next;
    logic push, pop;

    assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule : sample_fifo

// ======================================
// top
module sample_path_control #(
    parameter int ADC_W = 9,
    parameter int FRAC_W = 2,
    parameter int LINK_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ADC_W+FRAC_W-1:0] core_a_sample,
    input wire logic [ADC_W+FRAC_W-1:0] core_b_sample,
    input wire logic swap_active,
    input wire logic mux_select,
    input wire logic marker_in,
    input wire logic marker_input_receiver_enable,
    output logic out_valid,
    input wire logic out_ready,
    output logic [LINK_W-1:0] out_data,
    output logic [1:0] ila_control_bits,
    output logic mux_select_applied
);
    localparam int EXT_W = ADC_W + FRAC_W + 1;
    localparam int DLY_N = 1 << sample_path_pkg::SWAP_DLY_W;

    // ======================================
    // registers
    logic [7:0] swap_dly_reg, swap_dly_next;
    logic [7:0] dither_reg, dither_next;
    logic [7:0] marker_reg, marker_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_next;
    logic addr_hit;
    logic [31:0] rd_value;
    sample_path_pkg::ctrl_t ctrl;

    always_comb begin
        addr_hit = 1'b1;
        rd_value = '0;
        unique case (paddr[sample_path_pkg::ADDR_W-1:0])
            sample_path_pkg::SWAP_DLY_ADDR: rd_value = {24'h0000_00, swap_dly_reg};
            sample_path_pkg::DITHER_ADDR: rd_value = {24'h0000_00, dither_reg};
            sample_path_pkg::MARKER_ADDR: rd_value = {24'h0000_00, marker_reg};
            default: addr_hit = 1'b0;
        endcase
        if (paddr[31:sample_path_pkg::ADDR_W] != '0) begin
            addr_hit = 1'b0;
            rd_value = '0;
        end
        swap_dly_next = swap_dly_reg;
        dither_next = dither_reg;
        marker_next = marker_reg;
        // reserved bits are stored as written, software keeps them at default
        if (psel && penable && pwrite && addr_hit) begin
            unique case (paddr[sample_path_pkg::ADDR_W-1:0])
                sample_path_pkg::SWAP_DLY_ADDR: swap_dly_next = pwdata[7:0];
                sample_path_pkg::DITHER_ADDR: dither_next = pwdata[7:0];
                sample_path_pkg::MARKER_ADDR: marker_next = pwdata[7:0];
                default: ;
            endcase
        end
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            prdata_next = pwrite ? '0 : rd_value;
            pslverr_next = !addr_hit;
        end else if (psel && penable) begin
            pslverr_next = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swap_dly_reg <= sample_path_pkg::SWAP_DLY_RESET;
            dither_reg <= sample_path_pkg::DITHER_RESET;
            marker_reg <= sample_path_pkg::MARKER_RESET;
            prdata_reg <= '0;
            pslverr <= 1'b0;
        end else begin
            swap_dly_reg <= swap_dly_next;
            dither_reg <= dither_next;
            marker_reg <= marker_next;
            prdata_reg <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign ila_control_bits = sample_path_pkg::ILA_CTRL_BITS;

    always_comb begin
        ctrl.swap_dly = swap_dly_reg[sample_path_pkg::SWAP_DLY_MSB:0];
        ctrl.dith_err = dither_reg[sample_path_pkg::DITH_ERR_BIT];
        ctrl.dith_amp = dither_reg[sample_path_pkg::DITH_AMP_BIT];
        ctrl.dith_en = dither_reg[sample_path_pkg::DITH_EN_BIT];
        ctrl.marker_en = marker_reg[sample_path_pkg::MARKER_EN_BIT];
    end

    // ======================================
    // swap select delay line and dither source
    logic [DLY_N-1:0] sel_hist_reg, sel_hist_next;
    logic [15:0] lfsr_reg, lfsr_next;
    logic advance;
    logic fifo_in_ready;
    logic stage_valid_reg, stage_valid_next;
    logic [LINK_W-1:0] stage_data_reg, stage_data_next;

    assign in_ready = !stage_valid_reg || fifo_in_ready;
    assign advance = in_valid && in_ready;

    always_comb begin
        sel_hist_next = sel_hist_reg;
        lfsr_next = lfsr_reg;
        if (advance) begin
            sel_hist_next = {sel_hist_reg[DLY_N-2:0], mux_select};
            lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ sample_path_pkg::LFSR_TAPS)
                                    : (lfsr_reg >> 1);
        end
        // delay counted in accepted samples, only while a swap runs
        mux_select_applied = mux_select;
        if (swap_active && ctrl.swap_dly != '0) begin
            mux_select_applied = sel_hist_reg[ctrl.swap_dly - 1'b1];
        end
    end

    // ======================================
    // sample formatting stage
    logic [ADC_W+FRAC_W-1:0] picked;
    logic [EXT_W-1:0] dither_term, round_term, sum;
    logic [ADC_W-1:0] quant;
    logic marker_bit;

    always_comb begin
        picked = mux_select_applied ? core_b_sample : core_a_sample;
        dither_term = '0;
        if (ctrl.dith_en) begin
            dither_term = ctrl.dith_amp ? EXT_W'(lfsr_reg[FRAC_W:0])
                                        : EXT_W'(lfsr_reg[FRAC_W-1:0]);
        end
        // random rounding spreads error as noise, fixed half rounding gives offset and spurs
        round_term = ctrl.dith_err ? EXT_W'(1) << (FRAC_W - 1)
                                   : EXT_W'(lfsr_reg[15:16-FRAC_W]);
        sum = EXT_W'(picked) + dither_term + round_term;
        quant = sum[EXT_W-1] ? {ADC_W{1'b1}} : sum[EXT_W-2:FRAC_W];
        marker_bit = marker_in && marker_input_receiver_enable;
        stage_data_next = stage_data_reg;
        stage_valid_next = stage_valid_reg && !fifo_in_ready;
        if (advance) begin
            stage_valid_next = 1'b1;
            // marker rides the same register as its sample
            if (LINK_W > ADC_W) begin
                stage_data_next = {quant, {(LINK_W-ADC_W){1'b0}}};
                if (ctrl.marker_en) begin
                    stage_data_next[0] = marker_bit;
                end
            end else begin
                stage_data_next = LINK_W'(quant);
                if (ctrl.marker_en) begin
                    stage_data_next[0] = marker_bit;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_hist_reg <= '0;
            lfsr_reg <= sample_path_pkg::LFSR_SEED;
            stage_valid_reg <= 1'b0;
            stage_data_reg <= '0;
        end else begin
            sel_hist_reg <= sel_hist_next;
            lfsr_reg <= lfsr_next;
            stage_valid_reg <= stage_valid_next;
            stage_data_reg <= stage_data_next;
        end
    end

    // ======================================
    // output fifo
    sample_fifo #(
        .WIDTH(LINK_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(stage_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data(stage_data_reg),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );
endmodule : sample_path_control

// [sample_path_control_assertions.sv]
// checker: port properties of the sample path control
module sample_path_control_assertions #(
    parameter int ADC_W = 9,
    parameter int FRAC_W = 2,
    parameter int LINK_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [ADC_W+FRAC_W-1:0] core_a_sample,
    input wire logic [ADC_W+FRAC_W-1:0] core_b_sample,
    input wire logic swap_active,
    input wire logic mux_select,
    input wire logic marker_in,
    input wire logic marker_input_receiver_enable,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [LINK_W-1:0] out_data,
    input wire logic [1:0] ila_control_bits,
    input wire logic mux_select_applied
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================
    // shadow of delay field and last accepted select
    logic [4:0] dly_reg;
    logic sel_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_reg <= 5'h07;
            sel_reg <= 1'b0;
        end else begin
            if (psel && penable && pwrite && pready
                && paddr == {18'h0, sample_path_pkg::SWAP_DLY_ADDR}) begin
                dly_reg <= pwdata[4:0];
            end
            if (in_valid && in_ready) begin
                sel_reg <= mux_select;
            end
        end
    end
    // ======================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_accept;
        in_valid && in_ready;
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence
    property p_ila;
        ila_control_bits == 2'h0;
    endproperty
    a_ila: assert property (p_ila) else $error("control bits not zero");
    property p_plain;
        !swap_active |-> mux_select_applied == mux_select;
    endproperty
    a_plain: assert property (p_plain) else $error("select delayed off swap");
    property p_dly0;
        swap_active && dly_reg == 5'h00 |-> mux_select_applied == mux_select;
    endproperty
    a_dly0: assert property (p_dly0) else $error("zero delay not direct");
    property p_dly1;
        swap_active && dly_reg == 5'h01 |-> mux_select_applied == sel_reg;
    endproperty
    a_dly1: assert property (p_dly1) else $error("one sample delay wrong");
    property p_lat;
        s_accept |-> ##2 out_valid;
    endproperty
    a_lat: assert property (p_lat) else $error("sample latency wrong");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("output word changed");
    property p_mid;
        out_valid |-> out_data[LINK_W-ADC_W-1:1] == '0;
    endproperty
    a_mid: assert property (p_mid) else $error("bits under data not zero");
    property p_read;
        s_setup ##1 (psel && penable) |-> pready && prdata[31:8] == 24'h0;
    endproperty
    a_read: assert property (p_read) else $error("read word malformed");
endmodule : sample_path_control_assertions

bind sample_path_control sample_path_control_assertions #(.ADC_W(ADC_W), .FRAC_W(FRAC_W),
    .LINK_W(LINK_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);

// [sample_sink_model.sv]
// partner: link receiver that can stall and keeps every word
module sample_sink_model #(
    parameter int LINK_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [LINK_W-1:0] out_data,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [LINK_W-1:0] got[$];
    assign out_ready = !stall;
    always @(posedge pclk) begin
        if (presetn && out_valid && out_ready) begin
            got.push_back(out_data);
        end
    end
endmodule : sample_sink_model

// [sample_path_control_tb_top.sv]
// testbench: registers, sample stream, fill and swap select
module sample_path_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] A_SW = sample_path_pkg::SWAP_DLY_ADDR;
    localparam logic [13:0] A_DI = sample_path_pkg::DITHER_ADDR;
    localparam logic [13:0] A_MK = sample_path_pkg::MARKER_ADDR;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic in_valid = 1'b0, swap_active = 1'b0, mux_select = 1'b0, marker_in = 1'b0;
    logic marker_input_receiver_enable = 1'b0, stall = 1'b0;
    logic pready, pslverr, in_ready, out_valid, out_ready, mux_select_applied;
    logic [10:0] core_a_sample = 11'h0, core_b_sample = 11'h0;
    logic [15:0] out_data;
    logic [1:0] ila_control_bits;
    int mismatches = 0;
    int tests_run = 0;
    sample_path_control i_dut (.*);
    sample_sink_model i_sink (.*);
    initial begin
        forever #10 pclk = ~pclk;
    end
    // ======================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_range(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
        tests_run++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_range
    task automatic reg_op(input logic w, input logic [13:0] a, input logic [7:0] d,
                          input logic [31:0] er, input logic ee);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {18'h0, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        chk(prdata, er);
        chk(32'(pslverr), 32'(ee));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : reg_op
    // ======================================
    // scenarios
    task automatic t_regs();
        reg_op(0, A_SW, 8'h0, 32'h07, 0);
        reg_op(0, A_DI, 8'h0, 32'h0, 0);
        reg_op(0, A_MK, 8'h0, 32'h0, 0);
        reg_op(1, 14'h0010, 8'h0, 32'h0, 1);
        reg_op(1, A_SW, 8'h1f, 32'h0, 0);
        reg_op(0, A_SW, 8'h0, 32'h1f, 0);
        reg_op(1, A_DI, 8'h07, 32'h0, 0);
        reg_op(0, A_DI, 8'h0, 32'h07, 0);
        $display("register test done");
    endtask : t_regs
    task automatic t_stream(input logic [7:0] dith, input logic men, input logic ren);
        logic [15:0] exp[$];
        logic [10:0] s;
        int n;
        reg_op(1, A_DI, dith, 32'h0, 0);
        reg_op(1, A_MK, {7'h0, men}, 32'h0, 0);
        marker_input_receiver_enable <= ren;
        stall <= 1'b1;
        i_sink.got.delete();
        for (int i = 0; i < 17; i++) begin
            s = 11'(i * 68 + (dith[2] ? 2 : 0));
            core_a_sample <= s;
            core_b_sample <= ~s;
            marker_in <= i[0];
            in_valid <= 1'b1;
            exp.push_back({s[10:2] + 9'(dith[2]), 6'h0, i[0] & men & ren});
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (in_ready !== 1'b1 && n < 50);
            if (n >= 50) begin
                mismatches++;
            end
        end
        in_valid <= 1'b0;
        @(posedge pclk);
        chk(32'(in_ready), 32'h0);
        stall <= 1'b0;
        n = 0;
        while (i_sink.got.size() < 17 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(i_sink.got.size()), 32'h11);
        for (int i = 0; i < 17; i++) begin
            if (dith[0]) begin
                chk_range(32'(i_sink.got[i]), 32'(exp[i]), 32'(exp[i]) + (dith[1] ? 256 : 128));
            end else begin
                chk(32'(i_sink.got[i]), 32'(exp[i]));
            end
        end
        $display("stream test done");
    endtask : t_stream
    task automatic t_swap();
        reg_op(1, A_SW, 8'h00, 32'h0, 0);
        swap_active <= 1'b1;
        mux_select <= 1'b1;
        @(posedge pclk);
        chk(32'(mux_select_applied), 32'h1);
        reg_op(1, A_SW, 8'h01, 32'h0, 0);
        in_valid <= 1'b1;
        @(posedge pclk);
        mux_select <= 1'b0;
        in_valid <= 1'b0;
        @(posedge pclk);
        chk(32'(mux_select_applied), 32'h1);
        reg_op(1, A_SW, 8'h1f, 32'h0, 0);
        swap_active <= 1'b0;
        mux_select <= 1'b1;
        @(posedge pclk);
        chk(32'(mux_select_applied), 32'h1);
        $display("swap test done");
    endtask : t_swap
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_stream(8'h04, 1'b1, 1'b1);
        t_stream(8'h00, 1'b0, 1'b1);
        t_stream(8'h00, 1'b1, 1'b0);
        t_stream(8'h03, 1'b1, 1'b1);
        t_stream(8'h01, 1'b0, 1'b1);
        t_swap();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        summarize();
    end
endmodule : sample_path_control_tb_top
